// ===== logic/switch_csr_indirect_access.sv
// module: indirect access port from host registers to the fabric register space
// Functional notes
// - writing one to pending bit 31 starts a fabric access at target_index.
// - pending stays set during the fabric access and clears itself when done.
// - read data is in the data word before pending clears.
// - direction bit 30: zero writes the fabric register, one reads it.
// - step-up: data word write sets pending; index increments after the write.
// - step-up: data word read increments index and sets pending.
// - step-down: data word write sets pending; index decrements after the write.
// - step-down: data word read decrements index and sets pending.
// - step-up wins when both stepping options are set.
// - lane_select bits 19:16 gate fabric writes per byte.
// - lane bit 3 covers data 31:24 down to bit 0 covering 7:0.
// - target_index bits 15:0 addresses the fabric register.
// - data word read gives fabric data if reading, else last host write.
module switch_csr_indirect_access
    import csr_bridge_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        hsel_in,
    input  wire logic [11:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hwdata_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic [1:0]       hresp_out,
    output logic             fab_req_out,
    output logic             fab_read_out,
    output logic [15:0]      fab_index_out,
    output logic [3:0]       fab_lanes_out,
    output logic [31:0]      fab_wdata_out,
    input  wire logic        fab_ack_in,
    input  wire logic [31:0] fab_rdata_in
);
    import csr_bridge_pkg::*;

    typedef struct packed {
        seq_state_t  state;
        logic        pending;
        logic        direction;
        logic        step_up;
        logic        step_down;
        logic [3:0]  lanes;
        logic [15:0] index;
        logic [31:0] host_data;
        logic [31:0] fab_data;
        logic        step_after;
        logic [31:0] rdata;
        logic        rd_sel_cmd;
        logic        rd_sel_data;
    } core_state_t;

    core_state_t st_q;
    core_state_t st_d;
    logic        addr_ok;
    logic [31:0] cmd_view;
    logic [31:0] data_view;
    logic        pend_set;

    host_access_if acc ();

    ahb_reg_slave u_slave (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .hsel_in   (hsel_in),
        .haddr_in  (haddr_in),
        .htrans_in (htrans_in),
        .hwrite_in (hwrite_in),
        .hready_in (hready_in),
        .hwdata_in (hwdata_in),
        .acc       (acc)
    );

    // =====================================================================
    // index stepping, step-up first
    function automatic logic [15:0] step_index(input logic [15:0] idx, input logic up,
                                               input logic down);
        if (up) begin
            step_index = idx + 16'h0001;
        end else if (down) begin
            step_index = idx - 16'h0001;
        end else begin
            step_index = idx;
        end
    endfunction : step_index

    // =====================================================================
    // register views
    always_comb begin
        cmd_view = {st_q.pending, st_q.direction, st_q.step_up, st_q.step_down,
                    8'h00, st_q.lanes, st_q.index};
        data_view = st_q.direction ? st_q.fab_data : st_q.host_data;
    end

    // =====================================================================
    // core next state
    always_comb begin
        st_d    = st_q;
        addr_ok = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ || htrans_in == HTRANS_SEQ)
                  && !hwrite_in && hsize_in == 3'h2;
        // any host start in this cycle; it must beat the completion clear
        pend_set = (acc.wr_cmd && acc.wdata[BIT_PENDING])
                   || ((acc.wr_data || acc.rd_data) && (st_q.step_up || st_q.step_down));
        // read data registered at the address phase so hrdata comes from a flop
        if (addr_ok) begin
            st_d.rdata = (haddr_in == OFF_CMD_WORD) ? cmd_view :
                         (haddr_in == OFF_DATA_WORD) ? data_view : 32'h0000_0000;
        end
        st_d.rd_sel_cmd  = 1'b0;
        st_d.rd_sel_data = 1'b0;

        // host writes; no guard against writes while pending, the host keeps off
        if (acc.wr_cmd) begin
            st_d.direction = acc.wdata[BIT_DIRECTION];
            st_d.step_up   = acc.wdata[BIT_STEP_UP];
            st_d.step_down = acc.wdata[BIT_STEP_DOWN];
            st_d.lanes     = acc.wdata[LANE_LSB +: LANE_W];
            st_d.index     = acc.wdata[INDEX_W-1:0];
            st_d.step_after = 1'b0;
            if (acc.wdata[BIT_PENDING]) begin
                st_d.pending = 1'b1;
            end
        end
        if (acc.wr_data) begin
            st_d.host_data = acc.wdata;
            if (st_q.step_up || st_q.step_down) begin
                st_d.pending    = 1'b1;
                st_d.step_after = 1'b1;
            end
        end
        if (acc.rd_data && (st_q.step_up || st_q.step_down)) begin
            st_d.index      = step_index(st_q.index, st_q.step_up, st_q.step_down);
            st_d.pending    = 1'b1;
            st_d.step_after = 1'b0;
        end

        case (st_q.state)
            ST_IDLE: begin
                if (st_q.pending) begin
                    st_d.state = ST_REQ;
                end
            end
            ST_REQ: begin
                if (fab_ack_in) begin
                    if (st_q.direction) begin
                        st_d.fab_data = fab_rdata_in;
                    end
                    st_d.state = ST_DONE;
                end
            end
            ST_DONE: begin
                // set wins over the self-clear so a start landing here is not lost
                st_d.pending = pend_set;
                if (st_q.step_after) begin
                    st_d.index      = step_index(st_q.index, st_q.step_up, st_q.step_down);
                    st_d.step_after = 1'b0;
                end
                st_d.state = ST_IDLE;
            end
            default: begin
                st_d.state = ST_IDLE;
            end
        endcase
    end

    assign acc.rdata = data_view;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q           <= '0;
            st_q.state     <= ST_IDLE;
            st_q.lanes     <= LANE_RESET;
            st_q.index     <= INDEX_RESET;
            st_q.host_data <= DATA_RESET;
            st_q.fab_data  <= DATA_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // =====================================================================
    // outputs; fabric fields come straight from core registers, steady while pending only because the host keeps off
    assign hrdata_out    = st_q.rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = HRESP_OKAY;
    assign fab_req_out   = (st_q.state == ST_REQ);
    assign fab_read_out  = st_q.direction;
    assign fab_index_out = st_q.index;
    assign fab_lanes_out = st_q.lanes;
    assign fab_wdata_out = st_q.host_data;
endmodule : switch_csr_indirect_access

// ===== logic/csr_bridge_pkg.sv
// package: register map, command word fields and reset values of the indirect access port
package csr_bridge_pkg;
    // =====================================================================
    // register map
    localparam logic [11:0] OFF_DATA_WORD = 12'h1AC;
    localparam logic [11:0] OFF_CMD_WORD  = 12'h1B0;
    // =====================================================================
    // command word fields
    localparam int BIT_PENDING   = 31;
    localparam int BIT_DIRECTION = 30;
    localparam int BIT_STEP_UP   = 29;
    localparam int BIT_STEP_DOWN = 28;
    localparam int LANE_LSB      = 16;
    localparam int LANE_W        = 4;
    localparam int INDEX_W       = 16;
    // =====================================================================
    // reset values
    localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
    localparam logic [15:0] INDEX_RESET = 16'h0000;
    localparam logic [3:0]  LANE_RESET  = 4'h0;
    // =====================================================================
    // ahb-lite codes
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
    localparam logic [1:0]  HRESP_OKAY    = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ  = 2'b01,
        ST_DONE = 2'b10
    } seq_state_t;
endpackage : csr_bridge_pkg

// ===== logic/host_access_if.sv
// interface: decoded host register accesses between the bus slave and the bridge core
interface host_access_if;
    logic        wr_cmd;
    logic        wr_data;
    logic        rd_data;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave (output wr_cmd, output wr_data, output rd_data, output wdata, input rdata);
    modport core  (input wr_cmd, input wr_data, input rd_data, input wdata, output rdata);
endinterface : host_access_if

// ===== logic/ahb_reg_slave.sv
// module: ahb-lite slave front end, decodes writes of any size (hsize unchecked) to the two host registers and reads of the data word
module ahb_reg_slave
    import csr_bridge_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        hsel_in,
    input  wire logic [11:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hwdata_in,
    host_access_if.slave     acc
);
    typedef struct packed {
        logic wr_cmd;
        logic wr_data;
    } slv_state_t;
    slv_state_t st_q;
    slv_state_t st_d;
    logic       valid;

    // =====================================================================
    // address phase capture; writes land in the following data phase
    always_comb begin
        valid      = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ || htrans_in == HTRANS_SEQ);
        st_d.wr_cmd  = valid && hwrite_in && haddr_in == OFF_CMD_WORD;
        st_d.wr_data = valid && hwrite_in && haddr_in == OFF_DATA_WORD;
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign acc.wr_cmd  = st_q.wr_cmd;
    assign acc.wr_data = st_q.wr_data;
    assign acc.wdata   = hwdata_in;
    // a read is flagged in its address phase so the step takes effect after the word is sampled
    assign acc.rd_data = valid && !hwrite_in && haddr_in == OFF_DATA_WORD;
endmodule : ahb_reg_slave

// ===== verification/switch_csr_chk.sv
// checker: port assertions of the indirect access port
module switch_csr_chk
    import csr_bridge_pkg::*;
(
    input wire logic        mclk_in,
    input wire logic        rst_in,
    input wire logic [11:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic [1:0]  hresp_out,
    input wire logic        fab_req_out,
    input wire logic        fab_read_out,
    input wire logic [15:0] fab_index_out,
    input wire logic [3:0]  fab_lanes_out,
    input wire logic [31:0] fab_wdata_out,
    input wire logic        fab_ack_in
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // ====
    // data phase tracking; select and ready are always high on this bench
    logic        wr_q, rd_q, up_q, dn_q, dir_q, chain_q;
    logic [11:0] ad_q;
    logic [15:0] last_q;
    logic [31:0] dw_q;
    wire         cw   = wr_q && ad_q == OFF_CMD_WORD;
    wire         dacc = (wr_q || rd_q) && ad_q == OFF_DATA_WORD;
    wire  [15:0] nxt  = up_q ? last_q + 16'h0001 : last_q - 16'h0001;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            {wr_q, rd_q, up_q, dn_q, dir_q, chain_q, ad_q, last_q, dw_q} <= '0;
        end else begin
            wr_q <= htrans_in[1] && hwrite_in;
            rd_q <= htrans_in[1] && !hwrite_in;
            ad_q <= haddr_in;
            if (cw) {dir_q, up_q, dn_q} <= hwdata_in[30:28];
            if (wr_q && ad_q == OFF_DATA_WORD) dw_q <= hwdata_in;
            if (fab_req_out && fab_ack_in) last_q <= fab_index_out;
            // chain only after a stepped access, so the first one is not judged
            chain_q <= cw ? 1'b0 : chain_q | (fab_req_out & fab_ack_in & (up_q | dn_q));
        end
    end
    sequence cmd_go;
        cw && hwdata_in[BIT_PENDING] && !fab_req_out;
    endsequence
    sequence step_go;
        dacc && (up_q || dn_q) && chain_q && !fab_req_out;
    endsequence
    property p_fields;
        logic [31:0] c;
        (cmd_go, c = hwdata_in) |-> ##2 fab_req_out && fab_read_out == c[30]
            && fab_index_out == c[15:0] && fab_lanes_out == c[19:16];
    endproperty
    AST_FIELDS: assert property (p_fields)
        else $error("request fields wrong");
    AST_NOGO: assert property (cw && !hwdata_in[31] && !fab_req_out |-> ##1 !fab_req_out[*3])
        else $error("request without pending");
    AST_STEP: assert property (step_go |-> ##[1:2] fab_req_out && fab_index_out == nxt)
        else $error("stepped index wrong");
    AST_HOLD: assert property (fab_req_out && !fab_ack_in |=> fab_req_out
        && $stable(fab_index_out) && $stable(fab_wdata_out) && $stable(fab_lanes_out))
        else $error("request not held");
    AST_DROP: assert property (fab_req_out && fab_ack_in |=> !fab_req_out)
        else $error("request after ack");
    AST_RSV: assert property (rd_q && ad_q == OFF_CMD_WORD |-> hrdata_out[27:20] == 8'h00)
        else $error("unused bits set");
    AST_WDATA: assert property ($rose(fab_req_out) && !fab_read_out |-> fab_wdata_out == dw_q)
        else $error("write data wrong");
    AST_BACK: assert property (rd_q && ad_q == OFF_DATA_WORD && !dir_q && !up_q && !dn_q
        |-> hrdata_out == dw_q) else $error("data word readback wrong");
    AST_OKAY: assert property (hreadyout_out && hresp_out == HRESP_OKAY)
        else $error("bus response not okay");
endmodule : switch_csr_chk

// ===== verification/fabric_model.sv
// fabric model: register store answering the bridge, promptly or slowly
module fabric_model (
    input  wire logic        clk_in,
    input  wire logic        slow_in,
    input  wire logic        req_in,
    input  wire logic        read_in,
    input  wire logic [15:0] index_in,
    input  wire logic [3:0]  lanes_in,
    input  wire logic [31:0] wdata_in,
    output logic             ack_out = 1'b0,
    output logic [31:0]      rdata_out = 32'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [logic [15:0]];
    int          wt = 0;
    function automatic logic [31:0] peek(logic [15:0] i);
        return mem.exists(i) ? mem[i] : {~i, i};
    endfunction : peek
    function automatic logic [31:0] put(logic [31:0] o, logic [31:0] n, logic [3:0] l);
        for (int b = 0; b < 4; b++) if (l[b]) o[8*b+:8] = n[8*b+:8];
        return o;
    endfunction : put
    always @(posedge clk_in) begin
        rdata_out <= ~rdata_out; // outside an answer the data never holds still
        ack_out <= 1'b0;
        wt <= req_in ? wt + 1 : 0;
        if (req_in && !ack_out && wt >= (slow_in ? 4 : 0)) begin
            ack_out <= 1'b1;
            wt <= 0;
            if (read_in) rdata_out <= peek(index_in);
            else mem[index_in] = put(peek(index_in), wdata_in, lanes_in);
        end
    end
endmodule : fabric_model

// ===== verification/testbench.sv
// testbench: random and corner host sequences through the indirect access port
bind switch_csr_indirect_access switch_csr_chk u_chk (.mclk_in, .rst_in, .haddr_in, .htrans_in,
    .hwrite_in, .hwdata_in, .hrdata_out, .hreadyout_out, .hresp_out, .fab_req_out,
    .fab_read_out, .fab_index_out,
    .fab_lanes_out, .fab_wdata_out, .fab_ack_in);
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import csr_bridge_pkg::*;
    logic        mclk_in = 1'b0, rst_in = 1'b1, hw = 1'b0, slow = 1'b0, hrdy, ack, freq, frd;
    logic [1:0]  htr = 2'h0;
    logic [11:0] ha = 12'h000;
    logic [31:0] hwd = 32'h0, hrd, fwd, fdat, rd;
    logic [15:0] fidx;
    logic [3:0]  fl;
    int          miscompares = 0, checked = 0, cycles = 0;
    always #4 mclk_in = ~mclk_in;
    switch_csr_indirect_access u_dut (.mclk_in, .rst_in, .hsel_in(1'b1), .haddr_in(ha),
        .htrans_in(htr), .hwrite_in(hw), .hsize_in(3'h2), .hready_in(hrdy), .hwdata_in(hwd),
        .hrdata_out(hrd), .hreadyout_out(hrdy), .hresp_out(), .fab_req_out(freq),
        .fab_read_out(frd), .fab_index_out(fidx), .fab_lanes_out(fl), .fab_wdata_out(fwd),
        .fab_ack_in(ack), .fab_rdata_in(fdat));
    fabric_model u_fab (.clk_in(mclk_in), .slow_in(slow), .req_in(freq), .read_in(frd),
        .index_in(fidx), .lanes_in(fl), .wdata_in(fwd), .ack_out(ack), .rdata_out(fdat));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        if (miscompares == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        ha <= a;
        hw <= w;
        htr <= HTRANS_NONSEQ;
        do @(posedge mclk_in); while (hrdy !== 1'b1);
        htr <= 2'h0;
        hwd <= d;
        do @(posedge mclk_in); while (hrdy !== 1'b1);
        rd = hrd;
    endtask : bus
    task automatic idle(); // host only polls the command word while pending
        for (int n = 0; n < 40; n++) begin
            bus(1'b0, OFF_CMD_WORD, 32'h0);
            if (rd[BIT_PENDING] === 1'b0) break;
        end
        chk({31'h0, rd[BIT_PENDING]}, 32'h0);
    endtask : idle
    function automatic logic [31:0] mix(logic [31:0] o, logic [31:0] n, logic [3:0] l);
        logic [31:0] m;
        m = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
        return (o & ~m) | (n & m);
    endfunction : mix
    function automatic logic [31:0] cmd(logic [3:0] t, logic [3:0] l, logic [15:0] i);
        return {t, 8'h00, l, i};
    endfunction : cmd
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        logic [15:0] k, e;
        logic [31:0] d;
        logic [3:0]  l;
        void'($urandom(96768));
        repeat (6) @(posedge mclk_in);
        rst_in <= 1'b0;
        bus(1'b0, OFF_DATA_WORD, 32'h0);
        chk(rd, DATA_RESET);
        bus(1'b0, OFF_CMD_WORD, 32'h0);
        chk(rd, cmd(4'h0, LANE_RESET, INDEX_RESET));
        for (int i = 0; i < 8; i++) begin
            k = {4'(i), 12'($urandom)};
            d = $urandom;
            l = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
            slow <= i[0];
            bus(1'b1, OFF_DATA_WORD, d);
            bus(1'b1, OFF_CMD_WORD, cmd(4'h8, l, k) | 32'h0FF0_0000);
            bus(1'b0, OFF_DATA_WORD, 32'h0);
            chk(rd, d);
            idle();
            bus(1'b0, OFF_CMD_WORD, 32'h0);
            chk(rd, cmd(4'h0, l, k));
            bus(1'b1, OFF_CMD_WORD, cmd(4'hC, l, k));
            idle();
            bus(1'b0, OFF_DATA_WORD, 32'h0);
            chk(rd, mix({~k, k}, d, l));
        end
        for (int m = 1; m < 4; m++) begin
            k = 16'hF000 + 16'(m * 16);
            e = m[1] ? 16'h0001 : 16'hFFFF;
            slow <= m[0];
            bus(1'b1, OFF_CMD_WORD, cmd({2'b11, 2'(m)}, 4'hF, k)); // all lanes first
            idle();
            bus(1'b0, OFF_DATA_WORD, 32'h0);
            chk(rd, {~k, k});
            idle();
            bus(1'b0, OFF_CMD_WORD, 32'h0);
            chk(rd, cmd({2'b01, 2'(m)}, 4'hF, k + e));
            bus(1'b1, OFF_CMD_WORD, cmd(4'h4, 4'hF, k + e)); // stepping off before last read
            bus(1'b0, OFF_DATA_WORD, 32'h0);
            chk(rd, {~(k + e), k + e});
            bus(1'b1, OFF_CMD_WORD, cmd({2'b00, 2'(m)}, 4'hF, k));
            d = $urandom;
            bus(1'b1, OFF_DATA_WORD, d);
            idle();
            bus(1'b1, OFF_DATA_WORD, ~d);
            idle();
            bus(1'b0, OFF_CMD_WORD, 32'h0);
            chk(rd, cmd({2'b00, 2'(m)}, 4'hF, k + e + e));
            bus(1'b1, OFF_CMD_WORD, cmd(4'hC, 4'hF, k + e));
            idle();
            bus(1'b0, OFF_DATA_WORD, 32'h0);
            chk(rd, ~d);
        end
        end_of_test();
    end
endmodule : testbench
